//--- rtl/emx_pkg.sv
// emx_pkg: constants, frame layout and carrier types of the 16.384 Mbit/s
// receive back-plane multiplexer (four E1 channels per serial line).
// assumes one serial line per group of four channels and one timeslot word
// per group per 64 serial bit periods.
package emx_pkg;

  // geometry
  localparam int GROUPS     = 2;
  localparam int CHANNELS   = 4;
  localparam int OCTET_BITS = 8;
  localparam int SIG_BITS   = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int POS_W      = 11;

  // mode select field values (enable bit must also be one)
  localparam logic [1:0] MODE_HMVIP = 2'h2;
  localparam logic [1:0] MODE_H100  = 2'h3;

  // sync highs seen before the one that marks bit 0 of a frame
  localparam logic [2:0] HMVIP_PRIOR_HIGHS = 3'h2;
  localparam logic [2:0] H100_PRIOR_HIGHS  = 3'h1;
  localparam logic [2:0] RUN_MAX           = 3'h7;

  // two-flop sync delay: on a hit the line carries bit 2, the next bit is 3
  localparam logic [POS_W-1:0] SYNC_HIT_POS  = 11'h002;
  localparam logic [POS_W-1:0] SYNC_LOAD_POS = 11'h003;
  localparam logic [POS_W-1:0] FRAME_START   = 11'h000;
  localparam logic [5:0]       SLOT_START    = 6'h00;

  // fields of the frame bit position
  localparam int POS_CH_MSB   = 5;
  localparam int POS_CH_LSB   = 4;
  localparam int POS_HALF     = 3;
  localparam int POS_PAIR_MSB = 2;
  localparam int POS_PAIR_LSB = 1;
  localparam int POS_SIG      = 0;

  // fill sent when the source runs dry
  localparam logic [7:0] IDLE_PAYLOAD = 8'hFF;
  localparam logic [3:0] IDLE_SIG     = 4'hF;

  // payload[ch][7] is payload bit 1; sig[ch][3] is A, sig[ch][0] is D
  typedef struct packed {
    logic [CHANNELS-1:0][OCTET_BITS-1:0] payload;
    logic [CHANNELS-1:0][SIG_BITS-1:0]   sig;
  } emx_slot_s;

  localparam int SLOT_W = $bits(emx_slot_s);

  typedef enum logic [1:0] {
    EMX_HUNT  = 2'b00,
    EMX_ALIGN = 2'b01,
    EMX_SEND  = 2'b11
  } emx_link_e;

  // link-clock state shared by both groups
  typedef struct packed {
    logic       rst_q1;
    logic       rst_q2;
    logic       en_q1;
    logic       en_q2;
    logic [1:0] mode_q1;
    logic [1:0] mode_q2;
  } emx_lcom_s;

  // link-clock state of one group
  typedef struct packed {
    logic             sync_q1;
    logic             sync_q2;
    logic [2:0]       run;
    logic [POS_W-1:0] pos;
    emx_link_e        st;
    logic             full_q1;
    logic             full_q2;
    logic             seen;
    logic             take_tog;
    logic             under_tog;
    emx_slot_s        cur;
    logic             dout;
  } emx_lgrp_s;

  // reference-clock state of one group
  typedef struct packed {
    emx_slot_s stage;
    logic      full_tog;
    logic      take_q1;
    logic      take_q2;
    logic      under_q1;
    logic      under_q2;
    logic      under_q3;
    logic      under_pulse;
    logic      lock_q1;
    logic      lock_q2;
  } emx_rgrp_s;

endpackage

//--- rtl/emx_fifo.sv
// emx_fifo: flip-flop FIFO with valid/ready on both sides.
// assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module emx_fifo #(
  parameter int WIDTH = 48,
  parameter int DEPTH = 16
) (
  input  wire logic             ref_clk,   // clock
  input  wire logic             reset,     // synchronous reset, high
  input  wire logic             in_valid,  // write request
  output logic                  in_ready,  // room for a word
  input  wire logic [WIDTH-1:0] in_data,   // word written
  output logic                  out_valid, // word available
  input  wire logic             out_ready, // reader takes the word
  output logic [WIDTH-1:0]      out_data   // head word
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW+1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } emx_fifo_s;

  emx_fifo_s st_reg;
  emx_fifo_s st_next;
  logic      push;
  logic      pop;

  assign in_ready  = (st_reg.cnt != FULL_CNT);
  assign out_valid = (st_reg.cnt != '0);
  assign out_data  = st_reg.mem[st_reg.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    st_next = st_reg;
    if (push) begin
      st_next.mem[st_reg.wr] = in_data;
      st_next.wr = (st_reg.wr == LAST_PTR) ? '0 : AW'(st_reg.wr + 1'b1);
    end
    if (pop) begin
      st_next.rd = (st_reg.rd == LAST_PTR) ? '0 : AW'(st_reg.rd + 1'b1);
    end
    if (push && !pop) begin
      st_next.cnt = (AW+1)'(st_reg.cnt + 1'b1);
    end else if (pop && !push) begin
      st_next.cnt = (AW+1)'(st_reg.cnt - 1'b1);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

endmodule

//--- rtl/emx_rx_mux.sv
// emx_rx_mux: receive back-plane output in the HMVIP and H.100 16.384 Mbit/s
// modes. Per group of four E1 channels, timeslot words arrive on ref_clk
// through a FIFO and are serialised on the link clock onto one data line.
// assumes the far end supplies a free-running serial clock and frame sync,
// and that one timeslot word per group is offered every 64 serial periods.
//
// Functional notes
// - channels 0-3 go out on line 0, channels 4-7 on line 1
// - serial data changes on the rising edge of the serial clock
// - four 2.048 Mbit/s streams share one 16.384 Mbit/s line
// - within a timeslot channels go out in order 0, 1, 2, 3
// - first octet slot: payload bits 1-4, each sent twice
// - second octet slot: bits 5-8, each followed by signaling A-D
// - after timeslot N of all channels, timeslot N+1 follows
// - each channel's second octet slot uses the same insertion pattern
// - sampled sync high locates frame start, sending begins at the next frame start
// - enable one and mode 11 selects H.100
// - H.100 shares the HMVIP mapping, only sync position differs
// - enable one and mode 10 selects HMVIP
`timescale 1ns/1ps
module emx_rx_mux #(
  parameter int GROUPS     = emx_pkg::GROUPS,
  parameter int FIFO_DEPTH = emx_pkg::FIFO_DEPTH
) (
  input  wire logic                         ref_clk,             // system clock
  input  wire logic                         reset,               // sync reset, high
  input  wire logic                         rx_serial_clock_in,  // link clock
  input  wire logic [GROUPS-1:0]            rx_frame_sync_in,    // frame sync per group
  output logic      [GROUPS-1:0]            rx_serial_data_out,  // serial data per group
  input  wire logic                         rx_mux_enable,       // multiplex enable
  input  wire logic [1:0]                   rx_mode_select,      // interface mode
  input  wire logic [GROUPS-1:0]            ts_valid,            // timeslot word valid
  output logic      [GROUPS-1:0]            ts_ready,            // FIFO has room
  input  wire emx_pkg::emx_slot_s [GROUPS-1:0] ts_word,          // timeslot word
  output logic      [GROUPS-1:0]            rx_frame_locked,     // sending, ref_clk
  output logic      [GROUPS-1:0]            rx_underrun_pulse    // idle fill sent
);

  emx_pkg::emx_lcom_s lcom_reg;
  emx_pkg::emx_lcom_s lcom_next;
  logic               link_rst;
  logic               mode_ok;
  logic [2:0]         prior_highs;

  // mode bits are static pins of the ref domain; two flops into the link
  always_comb begin
    lcom_next         = lcom_reg;
    lcom_next.rst_q1  = reset;
    lcom_next.rst_q2  = lcom_reg.rst_q1;
    lcom_next.en_q1   = rx_mux_enable;
    lcom_next.en_q2   = lcom_reg.en_q1;
    lcom_next.mode_q1 = rx_mode_select;
    lcom_next.mode_q2 = lcom_reg.mode_q1;
  end

  always_ff @(posedge rx_serial_clock_in) begin
    lcom_reg <= lcom_next;
  end

  assign link_rst = lcom_reg.rst_q2;

  always_comb begin
    mode_ok = lcom_reg.en_q2 &&
              ((lcom_reg.mode_q2 == emx_pkg::MODE_HMVIP) ||
               (lcom_reg.mode_q2 == emx_pkg::MODE_H100));
    if (lcom_reg.mode_q2 == emx_pkg::MODE_H100) begin
      prior_highs = emx_pkg::H100_PRIOR_HIGHS;
    end else begin
      prior_highs = emx_pkg::HMVIP_PRIOR_HIGHS;
    end
  end

  // bit of the octet slot at a frame position
  // the lane is the low four position bits: half, pair and second-of-pair.
  // spelled out per lane so the wire order can be read straight off the table
  function automatic logic slot_bit(emx_pkg::emx_slot_s w,
                                    logic [emx_pkg::POS_W-1:0] p);
    logic [1:0] ch;
    logic [3:0] lane;
    logic [7:0] pay;
    logic [3:0] sig;
    logic       b;
    ch   = p[emx_pkg::POS_CH_MSB:emx_pkg::POS_CH_LSB];
    lane = p[emx_pkg::POS_HALF:emx_pkg::POS_SIG];
    pay  = w.payload[ch];
    sig  = w.sig[ch];
    // first octet slot: bits 1-4 doubled; second: bits 5-8, each followed by A-D
    case (lane)
      4'h0: begin
        b = pay[7];
      end
      4'h1: begin
        b = pay[7];
      end
      4'h2: begin
        b = pay[6];
      end
      4'h3: begin
        b = pay[6];
      end
      4'h4: begin
        b = pay[5];
      end
      4'h5: begin
        b = pay[5];
      end
      4'h6: begin
        b = pay[4];
      end
      4'h7: begin
        b = pay[4];
      end
      4'h8: begin
        b = pay[3];
      end
      4'h9: begin
        b = sig[3];
      end
      4'hA: begin
        b = pay[2];
      end
      4'hB: begin
        b = sig[2];
      end
      4'hC: begin
        b = pay[1];
      end
      4'hD: begin
        b = sig[1];
      end
      4'hE: begin
        b = pay[0];
      end
      default: begin
        b = sig[0];
      end
    endcase
    return b;
  endfunction

  // one serial line per four channels
  // each group has its own sync input
  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    emx_pkg::emx_lgrp_s lnk_reg;
    emx_pkg::emx_lgrp_s lnk_next;
    emx_pkg::emx_rgrp_s ref_reg;
    emx_pkg::emx_rgrp_s ref_next;
    emx_pkg::emx_slot_s fifo_data;
    emx_pkg::emx_slot_s idle_word;
    logic               fifo_valid;
    logic               stage_free;
    logic               hit;
    logic               have_new;

    always_comb begin
      for (int c = 0; c < emx_pkg::CHANNELS; c++) begin
        idle_word.payload[c] = emx_pkg::IDLE_PAYLOAD;
        idle_word.sig[c]     = emx_pkg::IDLE_SIG;
      end
    end

    emx_fifo #(
      .WIDTH (emx_pkg::SLOT_W),
      .DEPTH (FIFO_DEPTH)
    ) u_fifo (
      .ref_clk   (ref_clk),
      .reset     (reset),
      .in_valid  (ts_valid[g]),
      .in_ready  (ts_ready[g]),
      .in_data   (ts_word[g]),
      .out_valid (fifo_valid),
      .out_ready (stage_free),
      .out_data  (fifo_data)
    );

    // stage holds one word; it is free once the link has returned the toggle
    assign stage_free = (ref_reg.full_tog == ref_reg.take_q2);

    always_comb begin
      ref_next             = ref_reg;
      ref_next.take_q1     = lnk_reg.take_tog;
      ref_next.take_q2     = ref_reg.take_q1;
      ref_next.under_q1    = lnk_reg.under_tog;
      ref_next.under_q2    = ref_reg.under_q1;
      ref_next.under_q3    = ref_reg.under_q2;
      ref_next.under_pulse = ref_reg.under_q2 ^ ref_reg.under_q3;
      ref_next.lock_q1     = (lnk_reg.st == emx_pkg::EMX_SEND);
      ref_next.lock_q2     = ref_reg.lock_q1;
      if (stage_free && fifo_valid) begin
        ref_next.stage    = fifo_data;
        ref_next.full_tog = ~ref_reg.full_tog;
      end
    end

    always_ff @(posedge ref_clk) begin
      if (reset) begin
        ref_reg <= '0;
      end else begin
        ref_reg <= ref_next;
      end
    end

    assign rx_frame_locked[g]   = ref_reg.lock_q2;
    assign rx_underrun_pulse[g] = ref_reg.under_pulse;

    // sync run reaching its mark means the line now carries bit 2
    assign hit = lnk_reg.sync_q2 && (lnk_reg.run == prior_highs);
    assign have_new = (lnk_reg.full_q2 != lnk_reg.seen);

    always_comb begin
      lnk_next         = lnk_reg;
      lnk_next.sync_q1 = rx_frame_sync_in[g];
      lnk_next.sync_q2 = lnk_reg.sync_q1;
      lnk_next.full_q1 = ref_reg.full_tog;
      lnk_next.full_q2 = lnk_reg.full_q1;
      if (!lnk_reg.sync_q2) begin
        lnk_next.run = '0;
      end else if (lnk_reg.run != emx_pkg::RUN_MAX) begin
        lnk_next.run = 3'(lnk_reg.run + 3'h1);
      end
      // eleven-bit position wraps every 2048 periods
      // realign the position on a sync hit
      if (hit) begin
        lnk_next.pos = emx_pkg::SYNC_LOAD_POS;
      end else begin
        lnk_next.pos = lnk_reg.pos + 11'h001;
      end
      case (lnk_reg.st)
        emx_pkg::EMX_HUNT: begin
          if (hit) begin
            lnk_next.st = emx_pkg::EMX_ALIGN;
          end
        end
        emx_pkg::EMX_ALIGN: begin
          if (!hit && lnk_next.pos == emx_pkg::FRAME_START) begin
            lnk_next.st = emx_pkg::EMX_SEND;
          end
        end
        emx_pkg::EMX_SEND: begin
          // a sync out of place drops to a clean restart at the next frame
          if (hit && lnk_reg.pos != emx_pkg::SYNC_HIT_POS) begin
            lnk_next.st = emx_pkg::EMX_ALIGN;
          end
        end
        default: begin
          lnk_next.st = emx_pkg::EMX_HUNT;
        end
      endcase
      if (!mode_ok) begin
        lnk_next.st = emx_pkg::EMX_HUNT;
      end
      // next timeslot word at every 64-bit boundary
      if (lnk_next.st == emx_pkg::EMX_SEND &&
          lnk_next.pos[5:0] == emx_pkg::SLOT_START) begin
        if (have_new) begin
          lnk_next.cur      = ref_reg.stage;
          lnk_next.seen     = lnk_reg.full_q2;
          lnk_next.take_tog = ~lnk_reg.take_tog;
        end else begin
          lnk_next.cur       = idle_word;
          lnk_next.under_tog = ~lnk_reg.under_tog;
        end
      end
      // same pattern in every octet pair
      if (lnk_next.st == emx_pkg::EMX_SEND) begin
        lnk_next.dout = slot_bit(lnk_next.cur, lnk_next.pos);
      end else begin
        lnk_next.dout = 1'b0;
      end
    end

    // output register on the rising serial clock edge
    always_ff @(posedge rx_serial_clock_in) begin
      if (link_rst) begin
        lnk_reg     <= '0;
        lnk_reg.cur <= '1;
      end else begin
        lnk_reg <= lnk_next;
      end
    end

    // data stands a whole period, stable at the falling edge
    assign rx_serial_data_out[g] = lnk_reg.dout;
  end

endmodule

//--- tb/emx_rx_mux_props.sv
// emx_rx_mux_props: port-level checks of the receive back-plane multiplexer.
// assumes ref_clk and the link clock both run while reset is high.
`timescale 1ns/1ps
module emx_rx_mux_props #(
  parameter int GROUPS = 2
) (
  input wire logic              ref_clk,            // system clock
  input wire logic              reset,              // sync reset, high
  input wire logic              rx_serial_clock_in, // link clock
  input wire logic [GROUPS-1:0] rx_serial_data_out, // serial data
  input wire logic              rx_mux_enable,      // multiplex enable
  input wire logic [1:0]        rx_mode_select,     // interface mode
  input wire logic [GROUPS-1:0] ts_ready,           // FIFO room
  input wire logic [GROUPS-1:0] rx_frame_locked,    // sending
  input wire logic [GROUPS-1:0] rx_underrun_pulse   // idle fill sent
);
  logic [GROUPS-1:0] dout_lo_reg;
  logic [6:0]        gap_reg;
  logic              mode_ok;
  assign mode_ok = rx_mux_enable && rx_mode_select[1];
  always_ff @(negedge rx_serial_clock_in) dout_lo_reg <= rx_serial_data_out;
  // a timeslot is 64 link periods, some 77 ref_clk cycles; pulses 74 cycles apart still pass
  always_ff @(posedge ref_clk)
    gap_reg <= reset ? 7'h7F : rx_underrun_pulse[0] ? 7'h00 :
               gap_reg + {6'h00, gap_reg != 7'h7F};

  a_rise_edge_only: assert property (@(posedge rx_serial_clock_in)
    disable iff (reset) rx_serial_data_out == dout_lo_reg)
    else $error("serial data changed off the rising edge");
  a_idle_mode_zero: assert property (@(posedge rx_serial_clock_in)
    disable iff (reset) (!mode_ok) [*6] |-> rx_serial_data_out == '0)
    else $error("serial data not zero in an idle mode");
  a_lock_needs_mode: assert property (@(posedge ref_clk)
    disable iff (reset) rx_frame_locked != '0 |-> mode_ok)
    else $error("locked without a multiplexed mode");
  a_lock_reset_clear: assert property (@(posedge ref_clk)
    reset |=> rx_frame_locked == '0 && rx_underrun_pulse == '0)
    else $error("status not cleared by reset");
  a_data_reset_zero: assert property (@(posedge rx_serial_clock_in)
    reset [*4] |-> rx_serial_data_out == '0)
    else $error("serial data not zero in reset");
  a_ready_after_reset: assert property (@(posedge ref_clk)
    disable iff (reset) $fell(reset) |-> ts_ready == '1)
    else $error("FIFO not ready after reset");
  a_underrun_one_cycle: assert property (@(posedge ref_clk)
    disable iff (reset) rx_underrun_pulse[0] |=> !rx_underrun_pulse[0])
    else $error("underrun pulse longer than a cycle");
  a_underrun_spacing: assert property (@(posedge ref_clk)
    disable iff (reset) rx_underrun_pulse[0] |-> gap_reg >= 7'h49)
    else $error("underrun pulses closer than a timeslot");
  a_underrun_one_g1: assert property (@(posedge ref_clk)
    disable iff (reset) rx_underrun_pulse[1] |=> !rx_underrun_pulse[1])
    else $error("group 1 underrun pulse longer than a cycle");

  c_locked: cover property (@(posedge ref_clk) rx_frame_locked == '1);
  c_underrun: cover property (@(posedge ref_clk) rx_underrun_pulse[0]);
  c_full: cover property (@(posedge ref_clk) !reset && ts_ready == '0);
endmodule

bind emx_rx_mux emx_rx_mux_props #(.GROUPS(GROUPS)) i_emx_rx_mux_props (
  .ref_clk(ref_clk), .reset(reset), .rx_serial_clock_in(rx_serial_clock_in),
  .rx_serial_data_out(rx_serial_data_out), .rx_mux_enable(rx_mux_enable),
  .rx_mode_select(rx_mode_select), .ts_ready(ts_ready),
  .rx_frame_locked(rx_frame_locked), .rx_underrun_pulse(rx_underrun_pulse));

//--- tb/emx_far_end.sv
// emx_far_end: terminal equipment model: link clock, frame sync, bit capture.
// assumes bit 0 of a frame is driven in the period of frame position 0.
`timescale 1ns/1ps
module emx_far_end (
  input  wire logic       h100,    // two-period sync instead of four
  input  wire logic [1:0] dout,    // serial data from the framer
  output logic            sclk,    // link clock
  output logic [1:0]      sync,    // frame sync per group
  output logic [1:0]      cap,     // bits taken on the falling edge
  output logic [10:0]     cap_pos  // group 0 frame position of cap
);
  logic [10:0] pos = 11'h7F0;

  function automatic logic near(input logic [10:0] p, input logic h);
    return h ? (p + 11'h001) < 11'h002 : (p + 11'h002) < 11'h004;
  endfunction

  initial begin
    sclk = 1'b0;
    #7;
    forever #15 sclk = ~sclk;
  end
  always @(posedge sclk) pos <= pos + 11'h001;
  // sync around boundary; group 1 runs half a frame later
  assign sync = {near(pos ^ 11'h400, h100), near(pos, h100)};
  always @(negedge sclk) begin
    cap     <= dout;
    cap_pos <= pos;
  end
endmodule

//--- tb/tb.sv
// tb: self-checking bench of the receive back-plane multiplexer.
// assumes the far-end model makes the link clock and the frame sync.
`timescale 1ns/1ps
module tb;
  localparam int D = 2;
  logic                     ref_clk = 1'b0;
  logic                     reset = 1'b1;
  logic                     rx_mux_enable = 1'b0;
  logic [1:0]               rx_mode_select = 2'h2;
  logic [1:0]               ts_valid = 2'h0;
  emx_pkg::emx_slot_s [1:0] ts_word = '0;
  logic                     h100 = 1'b0;
  logic                     sclk;
  logic [1:0]               sync, dout, ts_ready, locked, under, cap;
  logic [10:0]              cap_pos, p;
  logic [63:0]              sh [2];
  bit   [1:0]               armed;
  emx_pkg::emx_slot_s       q [2][$];
  int                       miscompares = 0;
  int                       n_tests = 0;

  always #12.5 ref_clk = ~ref_clk;

  emx_rx_mux i_emx_rx_mux (
    .ref_clk(ref_clk), .reset(reset), .rx_serial_clock_in(sclk),
    .rx_frame_sync_in(sync), .rx_serial_data_out(dout),
    .rx_mux_enable(rx_mux_enable), .rx_mode_select(rx_mode_select),
    .ts_valid(ts_valid), .ts_ready(ts_ready), .ts_word(ts_word),
    .rx_frame_locked(locked), .rx_underrun_pulse(under));
  emx_far_end i_emx_far_end (.h100(h100), .dout(dout), .sclk(sclk),
    .sync(sync), .cap(cap), .cap_pos(cap_pos));

  task automatic compare(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    if (miscompares == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #D;
  endtask

  // never all ones, so an idle timeslot cannot pass for a word
  function automatic emx_pkg::emx_slot_s mk(input int g, input int k);
    emx_pkg::emx_slot_s w;
    for (int c = 0; c < 4; c++) begin
      w.payload[c] = 8'h5A ^ {k[3:0], c[1:0], g[0], 1'b1};
      w.sig[c]     = k[3:0] ^ {c[1:0], g[1:0]};
    end
    return w;
  endfunction

  function automatic logic [63:0] expand(input emx_pkg::emx_slot_s w);
    logic [63:0] e;
    for (int c = 0; c < 4; c++)
      for (int i = 0; i < 4; i++) begin
        e[63-16*c-2*i -: 2] = {2{w.payload[c][7-i]}};
        e[55-16*c-2*i -: 2] = {w.payload[c][3-i], w.sig[c][3-i]};
      end
    return e;
  endfunction

  // offers one word to each group and holds it until taken, for at most lim cycles
  task automatic push2(input int k, input int lim, output bit ok);
    logic [1:0] rdy;
    tick(1);
    ts_word  = {mk(1, k), mk(0, k)};
    ts_valid = 2'h3;
    for (int t = 0; t < lim && ts_valid != 2'h0; t++) begin
      rdy = ts_ready;
      tick(1);
      for (int g = 0; g < 2; g++)
        if (rdy[g] && ts_valid[g]) q[g].push_back(ts_word[g]);
      ts_valid = ts_valid & ~rdy;
    end
    ok = ts_valid == 2'h0;
  endtask

  // each captured timeslot is either idle fill or the oldest word taken
  always @(posedge sclk)
    for (int g = 0; g < 2; g++) begin
      p = cap_pos ^ (g ? 11'h400 : 11'h000);
      if (p[5:0] == 6'h00) armed[g] = locked[g] === 1'b1;
      if (reset) armed[g] = 1'b0;
      sh[g] = {sh[g][62:0], cap[g]};
      if (armed[g] && p[5:0] == 6'h3F && sh[g] !== '1)
        compare(sh[g], q[g].size() ? expand(q[g].pop_front()) : '1);
    end

  task automatic fill_refused;
    int n;
    bit ok;
    n = 0;
    ok = 1'b1;
    while (ok && n < 30) begin
      push2(n, 8, ok);
      n += ok;
    end
    compare(n inside {16, 17}, 1'b1);
    tick(5000);
    compare({ts_ready, locked}, 4'h0);
    rx_mux_enable = 1'b1;
    rx_mode_select = 2'h1;
    tick(5000);
    compare({ts_ready, locked}, 4'h0);
  endtask

  task automatic run_mode(input logic [1:0] mode, input logic h);
    bit ok;
    reset = 1'b1;
    ts_valid = 2'h0;
    rx_mux_enable = 1'b1;
    rx_mode_select = mode;
    h100 = h;
    q[0].delete();
    q[1].delete();
    tick(8);
    reset = 1'b0;
    for (int t = 0; t < 8000 && locked !== 2'h3; t++) tick(1);
    compare(locked, 2'h3);
    for (int t = 0; t < 200 && under[0] !== 1'b1; t++) tick(1);
    compare(under[0], 1'b1);
    for (int k = 0; k < 20; k++)
      push2(k, 200, ok);
    tick(2500);
    compare({q[1].size() == 0, q[0].size() == 0, ok}, 3'h7);
  endtask

  initial begin
    tick(8);
    reset = 1'b0;
    fill_refused();
    run_mode(emx_pkg::MODE_HMVIP, 1'b0);
    run_mode(emx_pkg::MODE_H100, 1'b1);
    report_and_stop();
  end

  initial begin
    #1000000;
    miscompares++;
    report_and_stop();
  end
endmodule
